// file: rtl/dram_pkg.sv
// shared constants and types for the display ram write addressing block
package dram_pkg;
  localparam int RAM_DEPTH = 80;
  localparam int ROW_COUNT = 4;
  localparam logic [6:0] LAST_ADDR = 7'h4F;
  localparam logic [1:0] BANK_ROW_OFS = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PTR = 8'h04;
  localparam logic [7:0] OFS_SUB = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // field positions
  localparam int BANK_IN_BIT = 1;
  localparam int BANK_OUT_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_MATCH_BIT = 2;
  localparam int STAT_HW_LSB = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // multiplex step time
  localparam int CLK_PERIOD_NS = 20;
  localparam int MUX_STEP_NS = 1000;
  localparam int MUX_STEP_CYC = MUX_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DM_1TO4 = 2'h0,
    DM_STATIC = 2'h1,
    DM_1TO2 = 2'h2,
    DM_1TO3 = 2'h3
  } dram_mode_t;

  localparam dram_mode_t MODE_RESET = DM_STATIC;

  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } dram_fill_state_t;

  // one bit written into the display ram
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [1:0] row;
    logic data;
  } dram_bitwr_t;

  // rows used per address in each drive mode
  function automatic logic [2:0] dram_rows(input dram_mode_t m);
    case (m)
      DM_STATIC: dram_rows = 3'h1;
      DM_1TO2: dram_rows = 3'h2;
      DM_1TO3: dram_rows = 3'h3;
      default: dram_rows = 3'h4;
    endcase
  endfunction

  function automatic logic dram_banked(input dram_mode_t m);
    dram_banked = (m == DM_STATIC) || (m == DM_1TO2);
  endfunction
endpackage

// file: rtl/dram_mem.sv
// 80 by 4 display ram, bit write port and registered full-row read port
`timescale 1ns/1ps
`default_nettype none
module dram_mem
  import dram_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dram_bitwr_t wr,
  input wire logic [1:0] rd_row,
  output logic [RAM_DEPTH-1:0] rd_data,
  output logic [1:0] rd_row_q
);
  logic [ROW_COUNT-1:0] cells [RAM_DEPTH];
  logic [RAM_DEPTH-1:0] next_rd_data;

  always_comb begin
    for (int i = 0; i < RAM_DEPTH; i++) begin
      next_rd_data[i] = cells[i][rd_row];
    end
  end

  always_ff @(posedge aclk) begin
    if (wr.en) begin
      cells[wr.addr][wr.row] <= wr.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
      rd_row_q <= 2'h0;
    end else begin
      rd_data <= next_rd_data;
      rd_row_q <= rd_row;
    end
  end
endmodule // dram_mem
`default_nettype wire

// file: rtl/dram_row_scan.sv
// output bank selector: steps through the displayed rows in multiplex order
`timescale 1ns/1ps
`default_nettype none
module dram_row_scan
  import dram_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dram_mode_t mode,
  input wire logic out_bank,
  output logic [1:0] scan_row
);
  logic [15:0] step_cnt;
  logic [15:0] next_step_cnt;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [2:0] rows;

  always_comb begin
    rows = dram_rows(mode);
    next_step_cnt = step_cnt + 16'h0001;
    next_phase = phase;
    if (step_cnt == 16'(MUX_STEP_CYC - 1)) begin
      next_step_cnt = 16'h0000;
      if ({1'b0, phase} >= rows - 3'h1) begin // R17
        next_phase = 2'h0;
      end else begin
        next_phase = phase + 2'h1;
      end
    end
    if ({1'b0, phase} >= rows) begin
      next_phase = 2'h0;
    end
    // alternate bank only in static and 1:2
    if (out_bank && dram_banked(mode)) begin // R18
      scan_row = phase + BANK_ROW_OFS;
    end else begin
      scan_row = phase;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt <= 16'h0000;
      phase <= 2'h0;
    end else begin
      step_cnt <= next_step_cnt;
      phase <= next_phase;
    end
  end
endmodule // dram_row_scan
`default_nettype wire

// file: rtl/dram_write_addr.sv
// display ram write addressing with axi4-lite control and row scan output
//
// Operation
// [R1] static: byte into row 0, eight addresses
// [R2] 1:2: bit pairs into rows 0,1
// [R3] 1:3: triples, row 2 third address untouched
// [R4] 1:4: quadruples into rows 0-3
// [R5] data bytes start at current pointer
// [R6] pointer advances 8, 4, 3, 2 per byte
// [R7] master reloads pointer after aborted transfer
// [R8] store only when counter equals pin subaddress
// [R9] device-select loads subaddress counter
// [R10] mismatch: no store, pointer still advances
// [R11] pointer overflow increments subaddress counter
// [R12] overflow mid-byte hands remaining bits onward
// [R13] master keeps subaddress pins stable
// [R14] next cascaded device stores and acknowledges overflow
// [R15] standalone device discards overflow, no acknowledge
// [R16] master repositions pointer for 1:3 row 2
// [R17] output rows scanned per drive mode
// [R18] output bank swaps to rows 2,3
// [R19] input bank writes rows 2,3
// [R20] input and output banks independent
// [R21] msb first, lowest row first
// [R22] bank bit1 input, bit0 output; 1:3/1:4 ignored
// [R23] pointer load 0 to 79
// [R24] device-select carries 3-bit subaddress
// [R25] mode code 01,10,11,00
`timescale 1ns/1ps
`default_nettype none
module dram_write_addr
  import dram_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_subaddr_bit0_pin,
  input wire logic hw_subaddr_bit1_pin,
  input wire logic hw_subaddr_bit2_pin,
  output logic [1:0] display_row,
  output logic [RAM_DEPTH-1:0] display_data
);
  // bus slave state
  logic aw_hold, next_aw_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_hold, next_w_hold;
  logic [31:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  // fill state
  dram_fill_state_t state, next_state;
  dram_mode_t mode, next_mode;
  logic [7:0] shreg, next_shreg;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] row_cnt, next_row_cnt;
  logic [6:0] ptr, next_ptr;
  logic [2:0] sub, next_sub;
  logic in_bank, next_in_bank;
  logic out_bank, next_out_bank;
  logic byte_ack, next_byte_ack;

  logic [2:0] hw_sub;
  logic match;
  logic wr_go;
  logic [2:0] rows;
  logic addr_done;
  logic [1:0] scan_row;
  dram_bitwr_t bitwr;

  assign hw_sub = {hw_subaddr_bit2_pin, hw_subaddr_bit1_pin, hw_subaddr_bit0_pin};
  assign match = (sub == hw_sub); // R8
  // a write commits only between bytes so it never disturbs a fill in progress
  assign wr_go = aw_hold && w_hold && !bvalid && (state == ST_IDLE);
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready = !w_hold;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // bus write and read channels
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !aw_hold) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        OFS_MODE, OFS_SUB, OFS_BANK, OFS_DATA: next_bresp = RESP_OKAY;
        OFS_PTR: begin
          if (w_lane0 && w_data[6:0] > LAST_ADDR) begin // R23
            next_bresp = RESP_SLVERR;
          end
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_MODE: next_rdata[1:0] = mode;
        OFS_PTR: next_rdata[6:0] = ptr;
        OFS_SUB: next_rdata[2:0] = sub;
        OFS_BANK: begin
          next_rdata[BANK_IN_BIT] = in_bank;
          next_rdata[BANK_OUT_BIT] = out_bank;
        end
        OFS_DATA: next_rdata[7:0] = shreg;
        OFS_STAT: begin
          next_rdata[STAT_BUSY_BIT] = (state != ST_IDLE);
          next_rdata[STAT_ACK_BIT] = byte_ack;
          next_rdata[STAT_MATCH_BIT] = match;
          next_rdata[STAT_HW_LSB +: 3] = hw_sub;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // byte fill: one bit per clock, msb first
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_row_cnt = row_cnt;
    next_ptr = ptr;
    next_sub = sub;
    next_in_bank = in_bank;
    next_out_bank = out_bank;
    next_byte_ack = byte_ack;
    rows = dram_rows(mode); // R1 R2 R3 R4
    addr_done = ({1'b0, row_cnt} == rows - 3'h1) || (bit_cnt == LAST_BIT); // R3
    bitwr.en = (state == ST_SHIFT) && match; // R10 R15
    bitwr.addr = ptr; // R5
    bitwr.data = shreg[7]; // R21
    if (in_bank && dram_banked(mode)) begin // R19 R20
      bitwr.row = row_cnt + BANK_ROW_OFS;
    end else begin
      bitwr.row = row_cnt;
    end
    case (state)
      ST_IDLE: begin
        if (wr_go && w_lane0) begin
          case (aw_addr)
            OFS_MODE: next_mode = dram_mode_t'(w_data[1:0]); // R25
            OFS_PTR: begin
              if (w_data[6:0] <= LAST_ADDR) begin
                next_ptr = w_data[6:0]; // R23
                next_row_cnt = 2'h0;
              end
            end
            OFS_SUB: next_sub = w_data[2:0]; // R9 R24
            OFS_BANK: begin
              if (dram_banked(mode)) begin // R22
                next_in_bank = w_data[BANK_IN_BIT];
                next_out_bank = w_data[BANK_OUT_BIT];
              end
            end
            OFS_DATA: begin
              next_shreg = w_data[7:0];
              next_bit_cnt = 3'h0;
              next_row_cnt = 2'h0;
              next_byte_ack = 1'b0;
              next_state = ST_SHIFT;
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_SHIFT: begin
        next_shreg = {shreg[6:0], 1'b0};
        next_bit_cnt = bit_cnt + 3'h1;
        next_byte_ack = byte_ack | match; // R14 R15
        if (addr_done) begin
          next_row_cnt = 2'h0;
          if (ptr == LAST_ADDR) begin
            next_ptr = 7'h00; // R12
            next_sub = sub + 3'h1; // R11
          end else begin
            next_ptr = ptr + 7'h01; // R6 R10
          end
        end else begin
          next_row_cnt = row_cnt + 2'h1;
        end
        if (bit_cnt == LAST_BIT) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      mode <= MODE_RESET;
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      row_cnt <= 2'h0;
      ptr <= 7'h00;
      sub <= 3'h0;
      in_bank <= 1'b0;
      out_bank <= 1'b0;
      byte_ack <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      row_cnt <= next_row_cnt;
      ptr <= next_ptr;
      sub <= next_sub;
      in_bank <= next_in_bank;
      out_bank <= next_out_bank;
      byte_ack <= next_byte_ack;
    end
  end

  dram_row_scan u_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode),
    .out_bank(out_bank),
    .scan_row(scan_row)
  );

  dram_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr(bitwr),
    .rd_row(scan_row),
    .rd_data(display_data),
    .rd_row_q(display_row)
  );
endmodule // dram_write_addr
`default_nettype wire

// file: dv/dram_write_addr_checker.sv
// concurrent checks on the bus handshake and the display row port
`timescale 1ns/1ps
`default_nettype none
module dram_write_addr_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] display_row
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && display_row == 2'h0)
    else $error("outputs not cleared by reset");
  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address accepted twice");
  a_w_taken: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("data accepted twice");
  a_b_bound: assert property (s_wr_taken |-> ##[1:12] s_axi_bvalid)
    else $error("write answer late");
  a_b_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_latency: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not next cycle");
  a_r_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule // dram_write_addr_checker
`default_nettype wire

// file: dv/dram_axi_master.sv
// bus master model: single writes and reads, answers taken promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module dram_axi_master (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // released lines show the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic slow;
    slow = 1'($urandom % 2);
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    if (slow) begin
      do @(posedge aclk); while (!s_axi_bvalid);
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic slow;
    slow = 1'($urandom % 2);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    if (slow) begin
      do @(posedge aclk); while (!s_axi_rvalid);
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // dram_axi_master
`default_nettype wire

// file: dv/test_dram_write_addr.sv
// self-checking bench for the display ram write addressing block
`timescale 1ns/1ps
`default_nettype none
module test_dram_write_addr;
  import dram_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, x, y;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [2:0] pins = 3'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, display_row;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [RAM_DEPTH-1:0] display_data;
  wire hw_subaddr_bit0_pin = pins[0];
  wire hw_subaddr_bit1_pin = pins[1];
  wire hw_subaddr_bit2_pin = pins[2];
  int bad_count = 0;
  int num_checks = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  dram_mode_t modes[4] = '{DM_STATIC, DM_1TO2, DM_1TO3, DM_1TO4};
  int steps[4] = '{8, 4, 3, 2};
  always #10 aclk = ~aclk;
  dram_write_addr dram_write_addr_i (.*);
  dram_axi_master dram_axi_master_i (.*);
  function automatic logic [7:0] rev(input logic [7:0] v);
    rev = {<<{v}};
  endfunction
  task automatic check(input string n, input logic [79:0] s, input logic [79:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    dram_axi_master_i.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    dram_axi_master_i.rd(a);
  endtask
  // byte fill lasts at most eight cycles
  task automatic settle;
    repeat (12) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      check("bresp", 80'(s_axi_bresp), 80'(bq.pop_front()));
    end
    if (s_axi_rvalid && s_axi_rready) begin
      check("rdata", 80'({s_axi_rresp, s_axi_rdata}), 80'(rq.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(90306));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_MODE, 32'h1, RESP_OKAY);
    rd(OFS_PTR, 32'h0, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_PTR, 32'h50, RESP_SLVERR);
    wr(OFS_PTR, 32'h4F, RESP_OKAY);
    rd(OFS_PTR, 32'h4F, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      x = 8'($urandom);
      wr(OFS_MODE, 32'(modes[i]), RESP_OKAY);
      wr(OFS_PTR, 32'h28, RESP_OKAY);
      wr(OFS_DATA, 32'(x), RESP_OKAY);
      settle();
      rd(OFS_PTR, 32'h28 + 32'(steps[i]), RESP_OKAY);
    end
    wr(OFS_BANK, 32'h3, RESP_OKAY);
    rd(OFS_BANK, 32'h0, RESP_OKAY);
    for (int r = 0; r < 4; r++) begin
      wait (display_row != 2'(r));
      wait (display_row == 2'(r));
      settle();
      check("quad", 80'(display_data[41:40]), 80'({x[3-r], x[7-r]}));
    end
    y = 8'($urandom);
    wr(OFS_MODE, 32'(DM_STATIC), RESP_OKAY);
    wr(OFS_BANK, 32'h0, RESP_OKAY);
    pins <= 3'(1 + $urandom % 7);
    @(posedge aclk);
    wr(OFS_SUB, 32'(pins), RESP_OKAY);
    wr(OFS_PTR, 32'h0, RESP_OKAY);
    wr(OFS_DATA, 32'(y), RESP_OKAY);
    settle();
    check("row0", 80'(display_data[7:0]), 80'(rev(y)));
    rd(OFS_STAT, 32'({pins, 3'b110}), RESP_OKAY);
    wr(OFS_SUB, 32'(pins - 3'h1), RESP_OKAY);
    wr(OFS_PTR, 32'h0, RESP_OKAY);
    wr(OFS_DATA, 32'(x), RESP_OKAY);
    settle();
    check("held", 80'(display_data[7:0]), 80'(rev(y)));
    rd(OFS_STAT, 32'({pins, 3'b000}), RESP_OKAY);
    rd(OFS_PTR, 32'h8, RESP_OKAY);
    wr(OFS_PTR, 32'h4C, RESP_OKAY);
    wr(OFS_DATA, 32'(x), RESP_OKAY);
    settle();
    rd(OFS_SUB, 32'(pins), RESP_OKAY);
    rd(OFS_PTR, 32'h4, RESP_OKAY);
    check("carry", 80'(display_data[3:0]), 80'(rev(x) >> 4));
    rd(OFS_STAT, 32'({pins, 3'b110}), RESP_OKAY);
    wr(OFS_PTR, 32'h4C, RESP_OKAY);
    wr(OFS_DATA, 32'(y), RESP_OKAY);
    settle();
    check("tail", 80'(display_data[79:76]), 80'(rev(y) & 8'h0F));
    rd(OFS_SUB, 32'(3'(pins + 3'h1)), RESP_OKAY);
    wr(OFS_SUB, 32'(pins), RESP_OKAY);
    wr(OFS_BANK, 32'h2, RESP_OKAY);
    wr(OFS_PTR, 32'h0, RESP_OKAY);
    wr(OFS_DATA, 32'(x), RESP_OKAY);
    settle();
    check("outrow", 80'(display_row), 80'h0);
    check("bank0", 80'(display_data[7:0]), 80'(rev({x[3:0], y[3:0]})));
    wr(OFS_BANK, 32'h1, RESP_OKAY);
    settle();
    check("outrow", 80'(display_row), 80'h2);
    check("bank2", 80'(display_data[7:0]), 80'(rev(x)));
    // 1:3 rewrite: second byte fills row 2 of the third address
    wr(OFS_MODE, 32'(DM_1TO3), RESP_OKAY);
    wr(OFS_PTR, 32'h0, RESP_OKAY);
    wr(OFS_DATA, 32'(x), RESP_OKAY);
    settle();
    wr(OFS_PTR, 32'h2, RESP_OKAY);
    wr(OFS_DATA, 32'(y), RESP_OKAY);
    settle();
    rd(OFS_PTR, 32'h5, RESP_OKAY);
    wait (display_row != 2'h2);
    wait (display_row == 2'h2);
    settle();
    check("fill3", 80'(display_data[3:0]), 80'({y[2], y[5], x[2], x[5]}));
    report_and_stop();
  end
endmodule // test_dram_write_addr
bind dram_write_addr dram_write_addr_checker dram_write_addr_checker_i (.*);
`default_nettype wire
